// ===== design/gpt_defs.svh
`ifndef GPT_DEFS_SVH
`define GPT_DEFS_SVH
`define GPT_OFF_CON1    12'h000
`define GPT_OFF_CNT1    12'h004
`define GPT_OFF_PER1    12'h008
`define GPT_OFF_CON2    12'h00c
`define GPT_OFF_CNT2    12'h010
`define GPT_OFF_PER2    12'h014
`define GPT_OFF_CON3    12'h018
`define GPT_OFF_CNT3    12'h01c
`define GPT_OFF_PER3    12'h020
`define GPT_OFF_HOLD3   12'h024
`define GPT_OFF_FLAGS   12'h028
`define GPT_OFF_CTRL    12'h02c
`define GPT_BIT_RUN     15
`define GPT_BIT_IDLE    13
`define GPT_BIT_ESRC_HI 9
`define GPT_BIT_ESRC_LO 8
`define GPT_BIT_GATE    6
`define GPT_BIT_PS_HI   5
`define GPT_BIT_PS_LO   4
`define GPT_BIT_CHAIN   3
`define GPT_BIT_SYNC    2
`define GPT_BIT_CSRC    1
`define GPT_CON1_MASK   16'ha376
`define GPT_CON2_MASK   16'ha37a
`define GPT_CON3_MASK   16'ha372
`define GPT_RST_CON     16'h0000
`define GPT_RST_PER     16'hffff
`endif

// ===== design/gpt_pkg.sv
package gpt_pkg;
  typedef struct packed {
    logic       run;
    logic       idle_halt;
    logic [1:0] ext_source_select;
    logic       gate_accumulate;
    logic [1:0] prescale_select;
    logic       pair_chain_mode;
    logic       ext_clock_sync;
    logic       clock_source_select;
  } gpt_ctrl_s;
  typedef struct packed {
    logic secondary_oscillator;
    logic low_power_rc_oscillator;
    logic first_timer_clock_pin;
    logic paired_timer_clock_pin;
    logic generic_timer_clock_in;
  } gpt_clk_in_s;
  typedef enum logic [1:0] {GPT_IDLE, GPT_WRESP, GPT_RRESP} gpt_bus_e;
endpackage

// ===== design/gpt_timers.sv
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "gpt_defs.svh"
module gpt_timers
  import gpt_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Device state and clock inputs
  input  wire logic        device_idle,
  input  wire logic        gate_in,
  input  wire gpt_clk_in_s clk_in,
  // Events
  output logic             adc_trigger
);
  typedef logic [15:0] gpt_word_t;

  gpt_word_t con_r [3];
  gpt_word_t con_nxt [3];
  gpt_word_t cnt_r [3];
  gpt_word_t cnt_nxt [3];
  gpt_word_t per_r [3];
  gpt_word_t per_nxt [3];
  logic [7:0] pre_r [3];
  logic [7:0] pre_nxt [3];
  gpt_word_t hold_r, hold_nxt;
  logic [2:0] flag_r, flag_nxt;
  logic [2:0] ie_r, ie_nxt;
  logic [4:0] ext_q_r, ext_q_nxt;
  logic [4:0] ext_s_r, ext_s_nxt;
  logic [4:0] ext_p_r, ext_p_nxt;
  logic gate_d_r, gate_d_nxt;
  logic adc_r, adc_nxt;
  gpt_bus_e st_r, st_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] resp_r, resp_nxt;
  logic aw_ok, w_ok, ar_ok;

  function automatic gpt_ctrl_s dec(input gpt_word_t c);
    dec.run                 = c[`GPT_BIT_RUN];
    dec.idle_halt           = c[`GPT_BIT_IDLE];
    dec.ext_source_select   = c[`GPT_BIT_ESRC_HI:`GPT_BIT_ESRC_LO];
    dec.gate_accumulate     = c[`GPT_BIT_GATE];
    dec.prescale_select     = c[`GPT_BIT_PS_HI:`GPT_BIT_PS_LO];
    dec.pair_chain_mode     = c[`GPT_BIT_CHAIN];
    dec.ext_clock_sync      = c[`GPT_BIT_SYNC];
    dec.clock_source_select = c[`GPT_BIT_CSRC];
  endfunction

  function automatic logic [7:0] ps_last(input logic [1:0] code);
    unique case (code)
      2'b11:   ps_last = 8'hff;
      2'b10:   ps_last = 8'h3f;
      2'b01:   ps_last = 8'h07;
      default: ps_last = 8'h00;
    endcase
  endfunction

  function automatic gpt_word_t rd_reg(input logic [11:0] a,
                                       input logic [2:0] s);
    rd_reg = 16'h0000;
    if (s[0]) rd_reg = con_r[0] & `GPT_CON1_MASK;
  endfunction

  // External sources: raw sample, two-stage synchronised, previous
  gpt_ctrl_s cf [3];
  logic [2:0] tick, match;
  logic chain, gate_fall, idle_stop;
  logic [2:0] src_sel;
  logic [2:0] raw_edge, sync_edge, ext_edge;
  logic [4:0] rise_raw, rise_sync;
  logic [2:0] wr_con;
  logic [31:0] cnt32, per32;

  always_comb begin
    for (int i = 0; i < 3; i++) cf[i] = dec(con_r[i]);
    chain = cf[1].pair_chain_mode;
    // Unsynchronised edge spans one sample so each pulse counts once
    rise_raw  = ext_q_r & ~ext_s_r;
    rise_sync = ext_s_r & ~ext_p_r;
    gate_fall = gate_d_r & ~gate_in;
    cnt32 = {cnt_r[2], cnt_r[1]};
    per32 = {per_r[2], per_r[1]};
  end

  // Edge on the selected extended source of each timer
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      unique case (cf[i].ext_source_select)
        2'b11:   src_sel[i] = 1'b0;
        2'b10:   src_sel[i] = 1'b0;
        2'b01:   src_sel[i] = 1'b0;
        default: src_sel[i] = 1'b0;
      endcase
      unique case (cf[i].ext_source_select)
        2'b11: begin
          raw_edge[i]  = rise_raw[0];
          sync_edge[i] = rise_sync[0];
        end
        2'b10: begin
          raw_edge[i]  = rise_raw[3];
          sync_edge[i] = rise_sync[3];
        end
        2'b01: begin
          raw_edge[i]  = (i == 0) ? rise_raw[2] : rise_raw[1];
          sync_edge[i] = (i == 0) ? rise_sync[2] : rise_sync[1];
        end
        default: begin
          raw_edge[i]  = rise_raw[4];
          sync_edge[i] = rise_sync[4];
        end
      endcase
      // Only timer one may count an unsynchronised clock
      ext_edge[i] = (i == 0 && !cf[0].ext_clock_sync) ?
                    raw_edge[i] : sync_edge[i];
    end
  end

  // Prescaler and counting enable
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      gpt_ctrl_s c;
      logic in_tick, run_ok;
      in_tick = 1'b0;
      run_ok = 1'b0;
      c = (chain && i == 2) ? cf[1] : cf[i];
      idle_stop = c.idle_halt && device_idle;
      run_ok = c.run && !idle_stop;
      if (c.clock_source_select)
        in_tick = ext_edge[(chain && i == 2) ? 1 : i];
      else if (c.gate_accumulate)
        in_tick = gate_in;
      else
        in_tick = 1'b1;
      pre_nxt[i] = pre_r[i];
      tick[i] = 1'b0;
      if (run_ok && in_tick) begin
        if (pre_r[i] >= ps_last(c.prescale_select)) begin
          pre_nxt[i] = 8'h00;
          tick[i] = 1'b1;
        end else begin
          pre_nxt[i] = pre_r[i] + 8'h01;
        end
      end
      if (wr_con[i] && c.run) pre_nxt[i] = 8'h00;
    end
  end

  always_comb begin
    match[0] = cnt_r[0] == per_r[0];
    match[1] = chain ? (cnt32 == per32) : (cnt_r[1] == per_r[1]);
    match[2] = chain ? match[1] : (cnt_r[2] == per_r[2]);
  end

  // Bus handshake decode
  always_comb begin
    aw_ok = st_r == GPT_IDLE && s_axi_awvalid && s_axi_wvalid;
    ar_ok = st_r == GPT_IDLE && !aw_ok && s_axi_arvalid;
    w_ok  = aw_ok && s_axi_wstrb[1:0] == 2'b11;
    wr_con[0] = w_ok && s_axi_awaddr == `GPT_OFF_CON1;
    wr_con[1] = w_ok && s_axi_awaddr == `GPT_OFF_CON2;
    wr_con[2] = w_ok && s_axi_awaddr == `GPT_OFF_CON3;
  end

  // Counters, flags and register writes
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      con_nxt[i] = con_r[i];
      per_nxt[i] = per_r[i];
      cnt_nxt[i] = cnt_r[i];
    end
    flag_nxt = flag_r;
    ie_nxt = ie_r;
    hold_nxt = hold_r;
    adc_nxt = 1'b0;
    gate_d_nxt = gate_in;
    if (w_ok) begin
      unique case (s_axi_awaddr)
        `GPT_OFF_CON1:  con_nxt[0] = s_axi_wdata[15:0] & `GPT_CON1_MASK;
        `GPT_OFF_CON2:  con_nxt[1] = s_axi_wdata[15:0] & `GPT_CON2_MASK;
        `GPT_OFF_CON3:  con_nxt[2] = s_axi_wdata[15:0] & `GPT_CON3_MASK;
        `GPT_OFF_CNT1:  cnt_nxt[0] = s_axi_wdata[15:0];
        `GPT_OFF_CNT2:  cnt_nxt[1] = s_axi_wdata[15:0];
        `GPT_OFF_CNT3:  cnt_nxt[2] = s_axi_wdata[15:0];
        `GPT_OFF_PER1:  per_nxt[0] = s_axi_wdata[15:0];
        `GPT_OFF_PER2:  per_nxt[1] = s_axi_wdata[15:0];
        `GPT_OFF_PER3:  per_nxt[2] = s_axi_wdata[15:0];
        `GPT_OFF_HOLD3: hold_nxt   = s_axi_wdata[15:0];
        `GPT_OFF_FLAGS: flag_nxt   = flag_r & ~s_axi_wdata[2:0];
        `GPT_OFF_CTRL:  ie_nxt     = s_axi_wdata[2:0];
        default: ;
      endcase
    end
    if (ar_ok && s_axi_araddr == `GPT_OFF_CNT2 && chain)
      hold_nxt = cnt_r[2];
    if (tick[0]) begin
      cnt_nxt[0] = match[0] ? 16'h0000 : cnt_r[0] + 16'h0001;
      if (match[0]) flag_nxt[0] = 1'b1;
    end
    if (cf[0].gate_accumulate && !cf[0].clock_source_select && cf[0].run
        && gate_fall)
      flag_nxt[0] = 1'b1;
    if (chain) begin
      if (tick[1]) begin
        {cnt_nxt[2], cnt_nxt[1]} = match[1] ? 32'h0 : cnt32 + 32'h1;
        if (match[1]) begin
          flag_nxt[2] = 1'b1;
          adc_nxt = 1'b1;
        end
      end
    end else begin
      for (int i = 1; i < 3; i++) begin
        if (tick[i]) begin
          cnt_nxt[i] = match[i] ? 16'h0000 : cnt_r[i] + 16'h0001;
          if (match[i]) flag_nxt[i] = 1'b1;
        end
      end
      adc_nxt = tick[2] && match[2];
    end
  end

  // Input sampling: first stage feeds the second and the unsynchronised edge detect
  always_comb begin
    ext_q_nxt = {clk_in.secondary_oscillator,
                 clk_in.low_power_rc_oscillator,
                 clk_in.first_timer_clock_pin,
                 clk_in.paired_timer_clock_pin,
                 clk_in.generic_timer_clock_in};
    ext_s_nxt = ext_q_r;
    ext_p_nxt = ext_s_r;
  end

  // Bus answer
  always_comb begin
    st_nxt = st_r;
    rdata_nxt = rdata_r;
    resp_nxt = resp_r;
    unique case (st_r)
      GPT_IDLE: begin
        if (aw_ok) begin
          st_nxt = GPT_WRESP;
          resp_nxt = (s_axi_awaddr <= `GPT_OFF_CTRL &&
                      s_axi_awaddr[1:0] == 2'b00) ? 2'b00 : 2'b10;
        end else if (ar_ok) begin
          st_nxt = GPT_RRESP;
          resp_nxt = 2'b00;
          unique case (s_axi_araddr)
            `GPT_OFF_CON1:  rdata_nxt = {16'h0, con_r[0]};
            `GPT_OFF_CON2:  rdata_nxt = {16'h0, con_r[1]};
            `GPT_OFF_CON3:  rdata_nxt = {16'h0, con_r[2]};
            `GPT_OFF_CNT1:  rdata_nxt = {16'h0, cnt_r[0]};
            `GPT_OFF_CNT2:  rdata_nxt = {16'h0, cnt_r[1]};
            `GPT_OFF_CNT3:  rdata_nxt = {16'h0, cnt_r[2]};
            `GPT_OFF_PER1:  rdata_nxt = {16'h0, per_r[0]};
            `GPT_OFF_PER2:  rdata_nxt = {16'h0, per_r[1]};
            `GPT_OFF_PER3:  rdata_nxt = {16'h0, per_r[2]};
            `GPT_OFF_HOLD3: rdata_nxt = {16'h0, hold_r};
            `GPT_OFF_FLAGS: rdata_nxt = {29'h0, flag_r};
            `GPT_OFF_CTRL:  rdata_nxt = {29'h0, ie_r};
            default: begin
              rdata_nxt = 32'h0;
              resp_nxt = 2'b10;
            end
          endcase
        end
      end
      GPT_WRESP: if (s_axi_bready) st_nxt = GPT_IDLE;
      GPT_RRESP: if (s_axi_rready) st_nxt = GPT_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) begin
        con_r[i] <= `GPT_RST_CON;
        cnt_r[i] <= 16'h0000;
        per_r[i] <= `GPT_RST_PER;
        pre_r[i] <= 8'h00;
      end
      hold_r <= 16'h0000;
      flag_r <= 3'h0;
      ie_r <= 3'h0;
      ext_q_r <= 5'h00;
      ext_s_r <= 5'h00;
      ext_p_r <= 5'h00;
      gate_d_r <= 1'b0;
      adc_r <= 1'b0;
      st_r <= GPT_IDLE;
      rdata_r <= 32'h0;
      resp_r <= 2'b00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      con_r <= con_nxt;
      cnt_r <= cnt_nxt;
      per_r <= per_nxt;
      pre_r <= pre_nxt;
      hold_r <= hold_nxt;
      flag_r <= flag_nxt;
      ie_r <= ie_nxt;
      ext_q_r <= ext_q_nxt;
      ext_s_r <= ext_s_nxt;
      ext_p_r <= ext_p_nxt;
      gate_d_r <= gate_d_nxt;
      adc_r <= adc_nxt;
      st_r <= st_nxt;
      rdata_r <= rdata_nxt;
      resp_r <= resp_nxt;
      s_axi_awready <= aw_ok;
      s_axi_wready <= aw_ok;
      s_axi_arready <= ar_ok;
    end
  end

  assign s_axi_bvalid = st_r == GPT_WRESP;
  assign s_axi_rvalid = st_r == GPT_RRESP;
  assign s_axi_bresp = resp_r;
  assign s_axi_rresp = resp_r;
  assign s_axi_rdata = rdata_r;
  assign adc_trigger = adc_r;

  a_ps_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_con[0] && cf[0].run |=> pre_r[0] == 8'h00)
    else $error("prescaler not cleared by control write");
  a_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !cf[0].run && !w_ok |=> $stable(cnt_r[0]))
    else $error("timer one counted while stopped");
  a_idle_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    cf[0].idle_halt && device_idle && !w_ok |=> $stable(cnt_r[0]))
    else $error("timer one counted in idle");
  a_wrap_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    tick[0] && match[0] && !w_ok |=> cnt_r[0] == 16'h0000)
    else $error("no wrap after match");
  a_flag_match: assert property (@(posedge aclk) disable iff (!aresetn)
    tick[0] && match[0] |=> flag_r[0])
    else $error("match flag lost");
  a_gate_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    cf[0].gate_accumulate && !cf[0].clock_source_select && cf[0].run
    && gate_fall |=> flag_r[0])
    else $error("gate fall flag lost");
  a_adc_src: assert property (@(posedge aclk) disable iff (!aresetn)
    adc_nxt |-> (chain ? tick[1] : tick[2]) && match[2])
    else $error("trigger from wrong timer");
  a_hold_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_ok && s_axi_araddr == `GPT_OFF_CNT2 && chain
    |=> hold_r == $past(cnt_r[2]))
    else $error("holding word not latched");
  a_chain_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    chain && tick[1] && match[1] |=> flag_r[2])
    else $error("chained match not on third flag");
  c_wrap: cover property (@(posedge aclk) tick[0] && match[0]);
  c_chain: cover property (@(posedge aclk) chain && tick[1] && match[1]);
  c_gate: cover property (@(posedge aclk) gate_fall && cf[0].gate_accumulate);
  c_adc: cover property (@(posedge aclk) adc_r);
endmodule

// ===== verification/gpt_timers_test.sv
`timescale 1ns/10ps
`include "gpt_defs.svh"
module gpt_timers_test
  import gpt_pkg::*;
;
  logic        aclk, aresetn, device_idle, gate_in, adc_trigger;
  logic [11:0] awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rd, a;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  gpt_clk_in_s clk_in;
  int          fails, total_checks, n;

  gpt_timers dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .device_idle(device_idle),
    .gate_in(gate_in), .clk_in(clk_in), .adc_trigger(adc_trigger));

  task automatic end_sim();
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(string nm, int lo, int hi, logic [31:0] g);
    total_checks++;
    if ($isunknown(g) || g < lo || g > hi) begin
      fails++;
      $display("CHECK FAILED %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask

  task automatic tmo();
    fails++;
    $display("CHECK FAILED bus answer expected response seen timeout");
    end_sim();
  endtask

  task automatic wr(logic [11:0] ad, logic [15:0] d, logic [1:0] er = 2'b00);
    int k;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (k == 50) tmo();
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic rdr(logic [11:0] ad, output logic [31:0] d,
                     output logic [1:0] r);
    int k;
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (k == 50) tmo();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(logic [11:0] ad, logic [15:0] e);
    rdr(ad, rd, rs);
    chk("rresp", 32'h0, 32'(rs));
    chk("rdata", {16'h0000, e}, rd);
  endtask

  task automatic meas(logic [11:0] ad, int cyc, output logic [31:0] d);
    logic [31:0] x;
    rdr(ad, x, rs);
    repeat (cyc) @(posedge aclk);
    rdr(ad, d, rs);
    d = (d - x) & 32'h0000ffff;
  endtask

  task automatic watch(int cyc, output int cnt);
    cnt = 0;
    repeat (cyc) begin
      @(posedge aclk);
      if (adc_trigger === 1'b1) cnt++;
    end
  endtask

  function automatic logic [15:0] cw(bit run, bit idl, logic [1:0] es,
      bit gt, logic [1:0] ps, bit syn, bit cs, bit ch = 1'b0);
    return {run, 1'b0, idl, 3'b000, es, 1'b0, gt, ps, ch, syn, cs, 1'b0};
  endfunction

  // One pulse train on the chosen extended source, 3 high 4 low
  task automatic pulses(logic [1:0] c, int cnt);
    gpt_clk_in_s s;
    s = '0;
    case (c)
      2'b11: s.generic_timer_clock_in = 1'b1;
      2'b10: s.low_power_rc_oscillator = 1'b1;
      2'b01: s.first_timer_clock_pin = 1'b1;
      default: s.secondary_oscillator = 1'b1;
    endcase
    repeat (cnt) begin
      @(posedge aclk);
      clk_in <= s;
      repeat (3) @(posedge aclk);
      clk_in <= '0;
      repeat (3) @(posedge aclk);
    end
  endtask

  task automatic t_regs();
    rdc(`GPT_OFF_CON1, 16'h0000);
    rdc(`GPT_OFF_PER1, 16'hffff);
    wr(`GPT_OFF_CON1, 16'hffff);
    rdc(`GPT_OFF_CON1, `GPT_CON1_MASK);
    wr(`GPT_OFF_CON2, 16'hffff);
    rdc(`GPT_OFF_CON2, `GPT_CON2_MASK);
    wr(`GPT_OFF_CON3, 16'hffff);
    rdc(`GPT_OFF_CON3, `GPT_CON3_MASK);
    wr(`GPT_OFF_CON1, 16'h0000);
    wr(`GPT_OFF_CON2, 16'h0000);
    wr(`GPT_OFF_CON3, 16'h0000);
    wr(12'h030, 16'h1234, 2'b10);
    rdr(12'h030, rd, rs);
    chk("unmapped rresp", 32'h2, 32'(rs));
    chk("unmapped rdata", 32'h0, rd);
  endtask

  task automatic t_prescale();
    int dv[4] = '{1, 8, 64, 256};
    for (int i = 0; i < 4; i++) begin
      wr(`GPT_OFF_CON1, cw(1, 0, 2'b00, 0, 2'(i), 0, 0));
      meas(`GPT_OFF_CNT1, 40 * dv[i], a);
      chk_rng("prescaled step", 39, 44, a);
    end
    wr(`GPT_OFF_CON1, 16'h0000);
    meas(`GPT_OFF_CNT1, 100, a);
    chk("stopped step", 32'h0, a);
  endtask

  task automatic t_idle_gate();
    wr(`GPT_OFF_CON1, cw(1, 1, 2'b00, 0, 2'b00, 0, 0));
    device_idle <= 1'b1;
    meas(`GPT_OFF_CNT1, 100, a);
    chk("idle halted step", 32'h0, a);
    wr(`GPT_OFF_CON1, cw(1, 0, 2'b00, 0, 2'b00, 0, 0));
    meas(`GPT_OFF_CNT1, 100, a);
    chk_rng("idle running step", 100, 106, a);
    device_idle <= 1'b0;
    wr(`GPT_OFF_CON1, cw(1, 0, 2'b00, 1, 2'b00, 0, 0));
    wr(`GPT_OFF_FLAGS, 16'h0007);
    meas(`GPT_OFF_CNT1, 100, a);
    chk("gate closed step", 32'h0, a);
    gate_in <= 1'b1;
    meas(`GPT_OFF_CNT1, 100, a);
    chk_rng("gate open step", 100, 106, a);
    gate_in <= 1'b0;
    repeat (4) @(posedge aclk);
    rdc(`GPT_OFF_FLAGS, 16'h0001);
    wr(`GPT_OFF_CON1, 16'h0000);
  endtask

  task automatic t_period();
    wr(`GPT_OFF_CNT1, 16'h0000);
    wr(`GPT_OFF_PER1, 16'h0005);
    wr(`GPT_OFF_FLAGS, 16'h0007);
    wr(`GPT_OFF_CON1, cw(1, 0, 2'b00, 0, 2'b00, 0, 0));
    repeat (60) @(posedge aclk);
    rdr(`GPT_OFF_CNT1, rd, rs);
    chk_rng("count within period", 0, 5, rd);
    wr(`GPT_OFF_CON1, 16'h0000);
    rdc(`GPT_OFF_FLAGS, 16'h0001);
    wr(`GPT_OFF_FLAGS, 16'h0001);
    rdc(`GPT_OFF_FLAGS, 16'h0000);
    wr(`GPT_OFF_PER1, 16'hffff);
  endtask

  // Last pass uses the unsynchronised path; gate bit set but ignored
  task automatic t_ext();
    for (int i = 0; i < 5; i++) begin
      wr(`GPT_OFF_CON1, cw(0, 0, 2'(i), 1, 2'b00, i < 4, 1));
      wr(`GPT_OFF_CNT1, 16'h0000);
      wr(`GPT_OFF_CON1, cw(1, 0, 2'(i), 1, 2'b00, i < 4, 1));
      pulses(2'(i), 5);
      pulses(2'(i + 1), 3);
      repeat (8) @(posedge aclk);
      rdc(`GPT_OFF_CNT1, 16'h0005);
    end
    wr(`GPT_OFF_CON1, 16'h0000);
  endtask

  task automatic t_pair16();
    wr(`GPT_OFF_PER2, 16'h0003);
    wr(`GPT_OFF_FLAGS, 16'h0007);
    wr(`GPT_OFF_CON2, cw(1, 0, 2'b00, 0, 2'b00, 0, 0));
    watch(100, n);
    chk("low timer trigger count", 32'h0, 32'(n));
    wr(`GPT_OFF_CON2, 16'h0000);
    rdr(`GPT_OFF_FLAGS, rd, rs);
    chk("low timer flag", 32'h2, rd & 32'h2);
    wr(`GPT_OFF_PER3, 16'h0003);
    wr(`GPT_OFF_CON3, cw(1, 0, 2'b00, 0, 2'b00, 0, 0));
    watch(100, n);
    chk_rng("high timer trigger count", 24, 26, 32'(n));
    wr(`GPT_OFF_CON3, 16'h0000);
  endtask

  task automatic t_chain();
    wr(`GPT_OFF_CNT2, 16'hfff0);
    wr(`GPT_OFF_CNT3, 16'h0000);
    wr(`GPT_OFF_PER2, 16'h0040);
    wr(`GPT_OFF_PER3, 16'h0001);
    wr(`GPT_OFF_CON3, cw(1, 0, 2'b00, 0, 2'b11, 0, 0));
    wr(`GPT_OFF_CON2, cw(1, 0, 2'b00, 0, 2'b00, 0, 0, 1));
    repeat (40) @(posedge aclk);
    wr(`GPT_OFF_CON2, cw(0, 0, 2'b00, 0, 2'b00, 0, 0, 1));
    rdr(`GPT_OFF_CNT2, rd, rs);
    chk_rng("chained low word", 0, 63, rd);
    rdc(`GPT_OFF_HOLD3, 16'h0001);
    rdc(`GPT_OFF_CNT3, 16'h0001);
    wr(`GPT_OFF_FLAGS, 16'h0007);
    wr(`GPT_OFF_CON2, cw(1, 0, 2'b00, 0, 2'b00, 0, 0, 1));
    watch(300, n);
    chk("chained trigger count", 32'h1, 32'(n));
    wr(`GPT_OFF_CON2, cw(0, 0, 2'b00, 0, 2'b00, 0, 0, 1));
    rdc(`GPT_OFF_FLAGS, 16'h0004);
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {device_idle, gate_in, awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    clk_in = '0;
    fails = 0;
    total_checks = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_prescale();
    t_idle_gate();
    t_period();
    t_ext();
    t_pair16();
    t_chain();
    end_sim();
  end
endmodule
